// file: verilog/adc_config_register_slice.sv
// configuration register slice behind the serial control port
`timescale 1ns/1ns

// How it works
// - read-only 24-bit alignment edge position status
// - 16-bit full-scale code, reset A000, all channels
// - power code resets 4B; 46 low power
// - timestamp control bit0 enables input receiver
// - timestamp control bit1 selects ECL termination
// - reference output driven only when synthesizer enabled
// - reference output enable resets to one
module adc_config_register_slice
  import adc_cfg_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // register access from the serial control port
  input  wire reg_req_t    req_i,
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  // status and interlock inputs from the rest of the device
  input  wire logic [23:0] alignment_edge_position_i,
  input  wire logic        synth_on_i,
  input  wire logic        calib_on_i,
  input  wire logic        serial_link_on_i,
  // controls toward the analog circuits
  output analog_ctl_t      ctl_o,
  output logic             pwr_change_unsafe_o
);

  // writable register storage; the position status is read live, not stored
  logic [15:0] fsr_reg;
  logic [7:0]  pwr_reg;
  logic [7:0]  ts_reg;
  logic [7:0]  ref_reg;

  // write strobe decode for one address, shared by the fsr_reg, pwr_reg, ts_reg and ref_reg processes
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = ce_i && req_i.wr && (req_i.addr == a);
  endfunction

  // read mux; one place holds the whole address map of this slice
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      ADDR_POS_0:  read_mux = alignment_edge_position_i[7:0];
      ADDR_POS_1:  read_mux = alignment_edge_position_i[15:8];
      ADDR_POS_2:  read_mux = alignment_edge_position_i[23:16];
      ADDR_FSR_0:  read_mux = fsr_reg[7:0];
      ADDR_FSR_1:  read_mux = fsr_reg[15:8];
      ADDR_PWR_A:  read_mux = pwr_reg;
      ADDR_TSTAMP: read_mux = ts_reg;
      ADDR_REFOUT: read_mux = ref_reg;
      default:     read_mux = 8'h00; // unmapped reads as zero
    endcase
  endfunction

  // full-scale range code, written a byte at a time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsr_reg <= FSR_RESET;
    end else begin
      if (wr_hit(ADDR_FSR_0)) fsr_reg[7:0] <= req_i.wdata;
      if (wr_hit(ADDR_FSR_1)) fsr_reg[15:8] <= req_i.wdata;
    end
  end

  // power mode code; stored as written so software can read back its set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_reg <= PWR_RESET;
    end else if (wr_hit(ADDR_PWR_A)) begin
      pwr_reg <= req_i.wdata;
    end
  end

  // flags a power-mode write made while calibration or the link still runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_change_unsafe_o <= 1'b0;
    end else if (ce_i) begin
      pwr_change_unsafe_o <= req_i.wr && req_i.addr == ADDR_PWR_A &&
                             (calib_on_i || serial_link_on_i);
    end
  end

  // timestamp and reference output control; reserved bits stored as written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ts_reg  <= TSTAMP_RESET;
      ref_reg <= REFOUT_RESET;
    end else begin
      if (wr_hit(ADDR_TSTAMP)) ts_reg <= req_i.wdata;
      if (wr_hit(ADDR_REFOUT)) ref_reg <= req_i.wdata;
    end
  end

  // registered analog controls; one cycle after the write lands
  // the reference output is held off in reset and, with the synthesizer on, rises one edge after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o.full_scale_range_code          <= FSR_RESET;
      ctl_o.power_mode_code_a              <= PWR_RESET;
      ctl_o.timestamp_receiver_on          <= 1'b0;
      ctl_o.timestamp_ecl_termination_mode <= 1'b0;
      ctl_o.reference_clock_output_on      <= 1'b0;
    end else if (ce_i) begin
      ctl_o.full_scale_range_code          <= fsr_reg;
      ctl_o.power_mode_code_a              <= pwr_reg;
      ctl_o.timestamp_receiver_on          <= ts_reg[TS_RECV_BIT];
      ctl_o.timestamp_ecl_termination_mode <= ts_reg[TS_ECL_BIT];
      ctl_o.reference_clock_output_on      <= ref_reg[REFOUT_BIT] && synth_on_i;
    end
  end

  // read data, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else if (ce_i) begin
      rvalid_o <= req_i.rd;
      rdata_o  <= req_i.rd ? read_mux(req_i.addr) : 8'h00;
    end
  end

  // checks compare each output against the inputs one edge earlier; a_ts_bits compares against the write two edges earlier
  a_refout_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> ctl_o.reference_clock_output_on == ($past(ref_reg[REFOUT_BIT]) && $past(synth_on_i)))
    else $error("reference output gating wrong");

  a_fsr_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_FSR_1 |=> fsr_reg[15:8] == $past(req_i.wdata))
    else $error("full-scale high byte not stored");

  a_pos_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.rd && req_i.addr == ADDR_POS_2 |=> rvalid_o && rdata_o == $past(alignment_edge_position_i[23:16]))
    else $error("position status read wrong");

  a_reset_vals: assert property (@(posedge clk_i)
    $past(rst_i) |-> pwr_reg == PWR_HIGH && fsr_reg == FSR_RESET && ref_reg == REFOUT_RESET && ts_reg == TSTAMP_RESET)
    else $error("reset values wrong");

  a_ts_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_TSTAMP ##1 ce_i |=> ctl_o.timestamp_receiver_on == $past(req_i.wdata[0], 2))
    else $error("timestamp receiver control wrong");

  a_ts_ecl: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> ctl_o.timestamp_ecl_termination_mode == $past(ts_reg[TS_ECL_BIT]))
    else $error("termination mode control wrong");

  a_ref_reset: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> ref_reg[REFOUT_BIT])
    else $error("reference enable not set at reset");

  a_pwr_unsafe: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_PWR_A && calib_on_i |=> pwr_change_unsafe_o)
    else $error("unsafe power change not flagged");

  a_link_unsafe: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_PWR_A && serial_link_on_i |=> pwr_change_unsafe_o)
    else $error("power change with link on not flagged");

  a_unsafe_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !calib_on_i && !serial_link_on_i |=> !pwr_change_unsafe_o)
    else $error("unsafe flag raised without interlock breach");

  a_fsr_low: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_FSR_0 |=> fsr_reg[7:0] == $past(req_i.wdata))
    else $error("full-scale low byte not stored");

  a_fsr_to_ctl: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> ctl_o.full_scale_range_code == $past(fsr_reg))
    else $error("full-scale code not passed to output");

  a_pwr_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_PWR_A |=> pwr_reg == $past(req_i.wdata))
    else $error("power mode code not stored");

  a_pwr_to_ctl: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> ctl_o.power_mode_code_a == $past(pwr_reg))
    else $error("power mode code not passed to output");

  a_pos_low: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.rd && req_i.addr == ADDR_POS_0 |=> rvalid_o && rdata_o == $past(alignment_edge_position_i[7:0]))
    else $error("position status low byte read wrong");

  a_pos_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_POS_0 |=>
      $stable(fsr_reg) && $stable(pwr_reg) && $stable(ts_reg) && $stable(ref_reg))
    else $error("write to position status changed a register");

  a_ts_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_TSTAMP |=> ts_reg == $past(req_i.wdata))
    else $error("timestamp control not stored");

  a_ref_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.wr && req_i.addr == ADDR_REFOUT |=> ref_reg == $past(req_i.wdata))
    else $error("reference output control not stored");

  a_ref_no_synth: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !synth_on_i |=> !ctl_o.reference_clock_output_on)
    else $error("reference output driven with synthesizer off");

  a_ctl_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> ctl_o.full_scale_range_code == FSR_RESET && ctl_o.power_mode_code_a == PWR_RESET &&
                     !ctl_o.reference_clock_output_on && !pwr_change_unsafe_o && !rvalid_o)
    else $error("output stage not at reset values");

  a_rvalid_rd: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req_i.rd |=> rvalid_o)
    else $error("read not answered");

  a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !req_i.rd |=> !rvalid_o && rdata_o == 8'h00)
    else $error("read data shown without a read");

  a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(fsr_reg) && $stable(pwr_reg) && $stable(ts_reg) && $stable(ref_reg) &&
              $stable(ctl_o) && $stable(rvalid_o) && $stable(rdata_o) && $stable(pwr_change_unsafe_o))
    else $error("state moved while clock enable low");

endmodule

// file: verilog/adc_cfg_pkg.sv
// constants, types and register map of the configuration register slice
package adc_cfg_pkg;

  // byte offsets of the eight-bit register space
  localparam logic [7:0] ADDR_POS_0    = 8'h2C;
  localparam logic [7:0] ADDR_POS_1    = 8'h2D;
  localparam logic [7:0] ADDR_POS_2    = 8'h2E;
  localparam logic [7:0] ADDR_FSR_0    = 8'h30;
  localparam logic [7:0] ADDR_FSR_1    = 8'h31;
  localparam logic [7:0] ADDR_PWR_A    = 8'h37;
  localparam logic [7:0] ADDR_TSTAMP   = 8'h3B;
  localparam logic [7:0] ADDR_REFOUT   = 8'h3C;

  // reset values
  localparam logic [15:0] FSR_RESET    = 16'hA000;
  localparam logic [7:0]  PWR_RESET    = 8'h4B;
  localparam logic [7:0]  TSTAMP_RESET = 8'h00;
  localparam logic [7:0]  REFOUT_RESET = 8'h01;

  // power mode codes; all others reserved
  localparam logic [7:0]  PWR_LOW      = 8'h46;
  localparam logic [7:0]  PWR_HIGH     = 8'h4B;

  // full-scale code limits
  localparam logic [15:0] FSR_MIN_REC  = 16'h2000;

  // field positions
  localparam int TS_RECV_BIT = 0;
  localparam int TS_ECL_BIT  = 1;
  localparam int REFOUT_BIT  = 0;

  // register read or write request carried on the control port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // controls driven toward the analog circuits
  typedef struct packed {
    logic [15:0] full_scale_range_code;
    logic [7:0]  power_mode_code_a;
    logic        timestamp_receiver_on;
    logic        timestamp_ecl_termination_mode;
    logic        reference_clock_output_on;
  } analog_ctl_t;

endpackage

// file: bench/tb_adc_config_register_slice.sv
// self-checking testbench for the configuration register slice
`timescale 1ns/1ns
module tb_adc_config_register_slice;
  import adc_cfg_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i  = 1'b1;
  reg_req_t    req_i = '0;
  logic [23:0] pos_i = 24'h000000;
  logic        synth_on_i = 1'b1;
  logic        calib_on_i = 1'b0;
  logic        link_on_i  = 1'b0;
  logic [7:0]  rdata_o;
  logic        rvalid_o;
  analog_ctl_t ctl_o;
  logic        unsafe_o;
  logic        unsafe_seen;
  int          fail_count = 0;
  int          n_compared = 0;
  always #20 clk_i = ~clk_i;
  adc_config_register_slice dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .alignment_edge_position_i(pos_i), .synth_on_i(synth_on_i), .calib_on_i(calib_on_i),
    .serial_link_on_i(link_on_i), .ctl_o(ctl_o), .pwr_change_unsafe_o(unsafe_o));
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request stands for one edge; the register lands there and ctl_o one edge later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= {1'b1, 1'b0, a, d};
    @(posedge clk_i);
    req_i <= '0;
    #1 unsafe_seen = unsafe_o;
    @(posedge clk_i);
    #1;
  endtask
  // read data stands for one cycle only, so it is sampled right after the answer edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    req_i <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    req_i <= '0;
    #1 chk("rvalid", 24'h000001, {23'h0, rvalid_o});
    chk($sformatf("rdata %h", a), {16'h0, exp}, {16'h0, rdata_o});
  endtask
  task automatic t_reset;
    chk("fsr out", 24'h00A000, {8'h0, ctl_o.full_scale_range_code});
    rd(ADDR_FSR_0, 8'h00);
    rd(ADDR_FSR_1, 8'hA0);
    rd(ADDR_PWR_A, 8'h4B);
    rd(ADDR_TSTAMP, 8'h00);
    rd(ADDR_REFOUT, 8'h01);
    chk("ref out", 24'h000001, {23'h0, ctl_o.reference_clock_output_on});
    rd(8'h40, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_position;
    @(posedge clk_i);
    pos_i <= 24'h5A3C96;
    wr(ADDR_POS_0, 8'hFF);
    rd(ADDR_POS_0, 8'h96);
    rd(ADDR_POS_1, 8'h3C);
    rd(ADDR_POS_2, 8'h5A);
    $display("test position done");
  endtask
  task automatic t_full_scale;
    wr(ADDR_FSR_0, 8'hFF);
    wr(ADDR_FSR_1, 8'hFF);
    chk("fsr max", 24'h00FFFF, {8'h0, ctl_o.full_scale_range_code});
    wr(ADDR_FSR_1, 8'h20);
    wr(ADDR_FSR_0, 8'h00);
    chk("fsr min", {8'h0, FSR_MIN_REC}, {8'h0, ctl_o.full_scale_range_code});
    rd(ADDR_FSR_1, 8'h20);
    $display("test full scale done");
  endtask
  task automatic t_power;
    @(posedge clk_i);
    calib_on_i <= 1'b1;
    wr(ADDR_PWR_A, PWR_LOW);
    chk("unsafe flag", 24'h000001, {23'h0, unsafe_seen});
    chk("pwr low", 24'h000046, {16'h0, ctl_o.power_mode_code_a});
    @(posedge clk_i);
    calib_on_i <= 1'b0;
    wr(ADDR_PWR_A, 8'h4B);
    chk("safe flag", 24'h000000, {23'h0, unsafe_seen});
    chk("pwr high", 24'h00004B, {16'h0, ctl_o.power_mode_code_a});
    @(posedge clk_i);
    link_on_i <= 1'b1;
    wr(ADDR_PWR_A, 8'h46);
    chk("link unsafe flag", 24'h000001, {23'h0, unsafe_seen});
    chk("pwr kept", 24'h000046, {16'h0, ctl_o.power_mode_code_a});
    @(posedge clk_i);
    link_on_i <= 1'b0;
    $display("test power done");
  endtask
  task automatic t_timestamp;
    wr(ADDR_TSTAMP, 8'h01);
    chk("ts recv", 24'h000001, {23'h0, ctl_o.timestamp_receiver_on});
    chk("ts ecl", 24'h000000, {23'h0, ctl_o.timestamp_ecl_termination_mode});
    wr(ADDR_TSTAMP, 8'h02);
    chk("ts recv off", 24'h000000, {23'h0, ctl_o.timestamp_receiver_on});
    chk("ts ecl on", 24'h000001, {23'h0, ctl_o.timestamp_ecl_termination_mode});
    $display("test timestamp done");
  endtask
  task automatic t_refout;
    wr(ADDR_REFOUT, 8'h00);
    chk("ref off", 24'h000000, {23'h0, ctl_o.reference_clock_output_on});
    wr(ADDR_REFOUT, 8'h01);
    chk("ref on", 24'h000001, {23'h0, ctl_o.reference_clock_output_on});
    @(posedge clk_i);
    synth_on_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk("ref no synth", 24'h000000, {23'h0, ctl_o.reference_clock_output_on});
    $display("test reference output done");
  endtask
  // a write while the enable is low must not land
  task automatic t_enable;
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(ADDR_FSR_1, 8'h55);
    chk("fsr frozen", 24'h002000, {8'h0, ctl_o.full_scale_range_code});
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd(ADDR_FSR_1, 8'h20);
    $display("test clock enable done");
  endtask
  // second reset in mid-run, with registers away from their reset values
  task automatic t_midreset;
    wr(ADDR_REFOUT, 8'h00);
    @(posedge clk_i);
    rst_i      <= 1'b1;
    synth_on_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk("ref out in reset", 24'h000000, {23'h0, ctl_o.reference_clock_output_on});
    chk("fsr after reset", 24'h00A000, {8'h0, ctl_o.full_scale_range_code});
    rd(ADDR_PWR_A, 8'h4B);
    rd(ADDR_TSTAMP, 8'h00);
    rd(ADDR_REFOUT, 8'h01);
    chk("ref out after reset", 24'h000001, {23'h0, ctl_o.reference_clock_output_on});
    $display("test mid-run reset done");
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // tests need under a hundred cycles; the watchdog allows well beyond that
  initial begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    $display("ERROR watchdog expected finish seen timeout");
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 t_reset();
    t_position();
    t_full_scale();
    t_power();
    t_timestamp();
    t_refout();
    t_enable();
    t_midreset();
    end_sim();
  end
endmodule
